// ### cfg_regs_pkg.sv
// package: register map, field layout and reset values of the config bank
package cfg_regs_pkg;

  // ==========================================================
  // bus widths
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 16;

  // ==========================================================
  // register addresses
  localparam logic [8:0] ADDR_CLKGEN = 9'h020;
  localparam logic [8:0] ADDR_LOGIC  = 9'h022;
  localparam logic [8:0] ADDR_IMCPWR = 9'h028;
  localparam logic [8:0] ADDR_IMCLVL = 9'h029;
  localparam logic [8:0] ADDR_AFEPWR = 9'h030;
  localparam logic [8:0] ADDR_BIASPW = 9'h040;
  localparam logic [8:0] ADDR_BIASRC = 9'h041;
  localparam logic [8:0] ADDR_AFECUR = 9'h042;
  localparam logic [8:0] ADDR_MUXCUR = 9'h043;
  localparam logic [8:0] ADDR_SERCUR = 9'h044;
  localparam logic [8:0] ADDR_AFEREF = 9'h046;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_CLKGEN = 16'h0004;
  localparam logic [15:0] RST_LOGIC  = 16'h0000;
  localparam logic [15:0] RST_IMCPWR = 16'h0000;
  localparam logic [15:0] RST_IMCLVL = 16'h1B5A;
  localparam logic [15:0] RST_AFEPWR = 16'h0000;
  localparam logic [15:0] RST_BIASPW = 16'h0000;
  localparam logic [15:0] RST_BIASRC = 16'h888B;
  localparam logic [15:0] RST_AFECUR = 16'h53C8;
  localparam logic [15:0] RST_MUXCUR = 16'h8888;
  localparam logic [15:0] RST_SERCUR = 16'h0088;
  localparam logic [15:0] RST_AFEREF = 16'h8888;

  // ==========================================================
  // field positions
  localparam int unsigned B_ANALOG_CLK  = 0;
  localparam int unsigned B_LOGIC_CLK   = 1;
  localparam int unsigned B_SEL_PLL     = 2;
  localparam int unsigned B_EIGHT_BIT   = 3;
  localparam int unsigned B_LOGIC_EN    = 0;
  localparam int unsigned B_CORE_PWR    = 0;
  localparam int unsigned B_MUX_PWR     = 1;
  localparam int unsigned B_COLBIAS_EN  = 2;
  localparam int unsigned B_AFE_PWR     = 0;
  localparam int unsigned B_BANDGAP_PWR = 0;
  localparam int unsigned B_EXT_RES     = 0;
  localparam int unsigned L_DS_LVL      = 0;
  localparam int unsigned L_TS_LVL      = 4;
  localparam int unsigned L_PRECHG      = 4;
  localparam int unsigned L_COLBIAS     = 8;
  localparam int unsigned L_CPUMP       = 12;
  localparam int unsigned L_MUX1        = 0;
  localparam int unsigned L_MUX2        = 4;
  localparam int unsigned NIB_W         = 4;

  // ==========================================================
  // bus request carrier
  typedef struct packed {
    logic [8:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // decoded controls towards the analog and clock blocks
  typedef struct packed {
    logic       analog_clk_en;
    logic       logic_clk_en;
    logic       sel_pll_clk;
    logic       eight_bit_mode;
    logic       logic_en;
    logic       core_pwr_up;
    logic       mux_pwr_up;
    logic       colbias_en;
    logic [3:0] double_slope_level;
    logic [3:0] triple_slope_level;
    logic       afe_pwr_up;
    logic       bandgap_pwr_up;
    logic       ext_resistor;
    logic [3:0] col_precharge_current;
    logic [3:0] col_bias_current;
    logic [3:0] charge_pump_current;
    logic [3:0] multiplexer_first_stage_current;
    logic [3:0] multiplexer_second_stage_current;
  } ctrl_t;

endpackage

// ### sensor_clock_bias_config_regs.sv
// module: clock generator, power and bias configuration register bank

// What this block does
// - clock generator bit 0 at 32 enables analog clocks, resets to zero
// - clock generator bit 1 enables the logic clock, resets to zero
// - clock generator bit 2 picks PLL clock when one, LVDS when zero
// - clock generator bit 3 picks 8-bit mode when one, 10-bit when zero
// - bit 0 at address 34 is the general logic enable, resets zero
// - address 40 bits 0 and 1 power up core and column mux
// - address 40 bit 2 enables the column bias, resets to zero
// - address 41 bits 3:0 hold double slope reset level, reset ten
// - address 41 bits 7:4 hold triple slope reset level, reset five
// - address 48 bit 0 powers up the eight column front ends
// - address 64 bit 0 powers up the bandgap, resets to zero
// - address 65 bit 0 selects external resistor when one, reset external
// - address 65 holds precharge, column bias, charge pump currents, reset eight
// - address 67 holds two multiplexer stage currents, each reset eight
module sensor_clock_bias_config_regs (
  input  wire logic                        mclk,
  input  wire logic                        reset_n,
  input  wire logic [8:0]                  addr,
  input  wire logic [15:0]                 wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [15:0]                 rdata,
  output logic                             rd_valid,
  output logic                             addr_err,
  output cfg_regs_pkg::ctrl_t              ctrl
);

  // ==========================================================
  // register index
  localparam int unsigned NREG = 11;
  localparam logic [8:0] ADDRS [NREG] = '{
    cfg_regs_pkg::ADDR_CLKGEN, cfg_regs_pkg::ADDR_LOGIC,
    cfg_regs_pkg::ADDR_IMCPWR, cfg_regs_pkg::ADDR_IMCLVL,
    cfg_regs_pkg::ADDR_AFEPWR, cfg_regs_pkg::ADDR_BIASPW,
    cfg_regs_pkg::ADDR_BIASRC, cfg_regs_pkg::ADDR_AFECUR,
    cfg_regs_pkg::ADDR_MUXCUR, cfg_regs_pkg::ADDR_SERCUR,
    cfg_regs_pkg::ADDR_AFEREF
  };
  localparam logic [15:0] RSTS [NREG] = '{
    cfg_regs_pkg::RST_CLKGEN, cfg_regs_pkg::RST_LOGIC,
    cfg_regs_pkg::RST_IMCPWR, cfg_regs_pkg::RST_IMCLVL,
    cfg_regs_pkg::RST_AFEPWR, cfg_regs_pkg::RST_BIASPW,
    cfg_regs_pkg::RST_BIASRC, cfg_regs_pkg::RST_AFECUR,
    cfg_regs_pkg::RST_MUXCUR, cfg_regs_pkg::RST_SERCUR,
    cfg_regs_pkg::RST_AFEREF
  };
  localparam int unsigned I_CLKGEN = 0;
  localparam int unsigned I_LOGIC  = 1;
  localparam int unsigned I_IMCPWR = 2;
  localparam int unsigned I_IMCLVL = 3;
  localparam int unsigned I_AFEPWR = 4;
  localparam int unsigned I_BIASPW = 5;
  localparam int unsigned I_BIASRC = 6;
  localparam int unsigned I_MUXCUR = 8;

  cfg_regs_pkg::bus_req_t req;
  logic [15:0]            regs_q [NREG];
  logic [15:0]            regs_d [NREG];
  logic [NREG-1:0]        hit;
  logic [15:0]            rdata_d;
  logic                   rd_valid_d;
  logic                   addr_err_d;
  logic [15:0]            rdata_q;
  logic                   rd_valid_q;
  logic                   addr_err_q;

  // bundle the bus signals
  assign req = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};

  // ==========================================================
  // storage, one full 16-bit word per register
  // reserved bits are kept as written so read-modify-write is exact
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      assign hit[g] = (req.addr == ADDRS[g]);

      // next value: write replaces the whole word
      always_comb begin
        regs_d[g] = regs_q[g];
        if (req.wr && hit[g]) begin
          regs_d[g] = req.wdata;
        end
      end

      // register with documented reset value
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          regs_q[g] <= RSTS[g];
        end else begin
          regs_q[g] <= regs_d[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // read path: data one cycle after the strobe, zero elsewhere
  always_comb begin
    rdata_d    = 16'h0000;
    rd_valid_d = 1'b0;
    addr_err_d = 1'b0;
    if (req.rd) begin
      rd_valid_d = 1'b1;
      addr_err_d = ~|hit;           // unmapped reads return zero
      for (int i = 0; i < NREG; i++) begin
        if (hit[i]) begin
          rdata_d = regs_q[i];
        end
      end
    end else if (req.wr) begin
      addr_err_d = ~|hit;           // unmapped writes are dropped
    end
  end

  // read data and status flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q    <= 16'h0000;
      rd_valid_q <= 1'b0;
      addr_err_q <= 1'b0;
    end else begin
      rdata_q    <= rdata_d;
      rd_valid_q <= rd_valid_d;
      addr_err_q <= addr_err_d;
    end
  end

  assign rdata    = rdata_q;
  assign rd_valid = rd_valid_q;
  assign addr_err = addr_err_q;

  // ==========================================================
  // clock generator controls
  always_comb begin
    ctrl = '0;
    ctrl.analog_clk_en  =
      regs_q[I_CLKGEN][cfg_regs_pkg::B_ANALOG_CLK];
    ctrl.logic_clk_en   =
      regs_q[I_CLKGEN][cfg_regs_pkg::B_LOGIC_CLK];
    ctrl.sel_pll_clk    =
      regs_q[I_CLKGEN][cfg_regs_pkg::B_SEL_PLL];
    ctrl.eight_bit_mode =
      regs_q[I_CLKGEN][cfg_regs_pkg::B_EIGHT_BIT];
    // logic and image core controls
    ctrl.logic_en       =
      regs_q[I_LOGIC][cfg_regs_pkg::B_LOGIC_EN];
    ctrl.core_pwr_up    =
      regs_q[I_IMCPWR][cfg_regs_pkg::B_CORE_PWR];
    ctrl.mux_pwr_up     =
      regs_q[I_IMCPWR][cfg_regs_pkg::B_MUX_PWR];
    ctrl.colbias_en     =
      regs_q[I_IMCPWR][cfg_regs_pkg::B_COLBIAS_EN];
    ctrl.double_slope_level = regs_q[I_IMCLVL]
      [cfg_regs_pkg::L_DS_LVL +: cfg_regs_pkg::NIB_W];
    ctrl.triple_slope_level = regs_q[I_IMCLVL]
      [cfg_regs_pkg::L_TS_LVL +: cfg_regs_pkg::NIB_W];
    // front end and bias controls
    ctrl.afe_pwr_up     =
      regs_q[I_AFEPWR][cfg_regs_pkg::B_AFE_PWR];
    ctrl.bandgap_pwr_up =
      regs_q[I_BIASPW][cfg_regs_pkg::B_BANDGAP_PWR];
    ctrl.ext_resistor   =
      regs_q[I_BIASRC][cfg_regs_pkg::B_EXT_RES];
    ctrl.col_precharge_current = regs_q[I_BIASRC]
      [cfg_regs_pkg::L_PRECHG +: cfg_regs_pkg::NIB_W];
    ctrl.col_bias_current = regs_q[I_BIASRC]
      [cfg_regs_pkg::L_COLBIAS +: cfg_regs_pkg::NIB_W];
    ctrl.charge_pump_current = regs_q[I_BIASRC]
      [cfg_regs_pkg::L_CPUMP +: cfg_regs_pkg::NIB_W];
    ctrl.multiplexer_first_stage_current = regs_q[I_MUXCUR]
      [cfg_regs_pkg::L_MUX1 +: cfg_regs_pkg::NIB_W];
    ctrl.multiplexer_second_stage_current = regs_q[I_MUXCUR]
      [cfg_regs_pkg::L_MUX2 +: cfg_regs_pkg::NIB_W];
  end

endmodule

// ### sensor_clock_bias_config_regs_assertions.sv
// checker: concurrent properties on the config bank ports
module sensor_clock_bias_config_regs_assertions (
  input wire logic                mclk,
  input wire logic                reset_n,
  input wire logic [8:0]          addr,
  input wire logic [15:0]         wdata,
  input wire logic                wr_en,
  input wire logic                rd_en,
  input wire logic [15:0]         rdata,
  input wire logic                rd_valid,
  input wire logic                addr_err,
  input wire cfg_regs_pkg::ctrl_t ctrl
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // write step and write then read of the same word
  sequence s_wr(logic [8:0] a);
    wr_en && addr == a;
  endsequence
  sequence s_wr_rd;
    wr_en ##1 (rd_en && addr == $past(addr));
  endsequence
  // ==========================================================
  // decoded fields follow the written word
  AST_ANALOG_CLK: assert property (s_wr(cfg_regs_pkg::ADDR_CLKGEN) |=>
    ctrl.analog_clk_en == $past(wdata[0])) else $error("analog clk bad");
  AST_SEL_PLL: assert property (s_wr(cfg_regs_pkg::ADDR_CLKGEN) |=>
    ctrl.sel_pll_clk == $past(wdata[2])) else $error("clock select bad");
  AST_DS_LEVEL: assert property (s_wr(cfg_regs_pkg::ADDR_IMCLVL) |=>
    ctrl.double_slope_level == $past(wdata[3:0])) else $error("ds bad");
  AST_EXT_RES: assert property (s_wr(cfg_regs_pkg::ADDR_BIASRC) |=>
    ctrl.ext_resistor == $past(wdata[0])) else $error("resistor bad");
  AST_MUX2: assert property (s_wr(cfg_regs_pkg::ADDR_MUXCUR) |=>
    ctrl.multiplexer_second_stage_current == $past(wdata[7:4]))
    else $error("mux stage 2 bad");
  // ==========================================================
  // controls hold, read path answers once
  AST_CTRL_HOLD: assert property (!wr_en |=> $stable(ctrl))
    else $error("ctrl moved without write");
  AST_READBACK: assert property (s_wr_rd |=>
    addr_err || rdata == $past(wdata, 2)) else $error("readback bad");
  AST_RDATA_IDLE: assert property (!rd_valid |-> rdata == 16'h0000)
    else $error("rdata not idle");
  AST_VALID_CAUSE: assert property (!rd_en |=> !rd_valid)
    else $error("valid without read");
  AST_ERR_CAUSE: assert property (!(wr_en || rd_en) |=> !addr_err)
    else $error("error without strobe");
endmodule

// ### sensor_clock_bias_config_regs_tb.sv
// testbench: register access and decoded controls of the config bank
module sensor_clock_bias_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                mclk = 1'b0;
  logic                reset_n = 1'b0;
  logic                wr_en = 1'b0;
  logic                rd_en = 1'b0;
  logic [8:0]          addr = 9'h000;
  logic [15:0]         wdata = 16'h0000;
  logic [15:0]         rdata;
  logic                rd_valid;
  logic                addr_err;
  cfg_regs_pkg::ctrl_t ctrl;
  int                  error_cnt = 0;
  int                  compares = 0;
  logic [8:0]          amap [11] = '{9'h020, 9'h022, 9'h028, 9'h029,
    9'h030, 9'h040, 9'h041, 9'h042, 9'h043, 9'h044, 9'h046};
  logic [15:0]         rstv [11] = '{16'h0004, 16'h0000, 16'h0000,
    16'h1B5A, 16'h0000, 16'h0000, 16'h888B, 16'h53C8, 16'h8888,
    16'h0088, 16'h8888};
  sensor_clock_bias_config_regs sensor_clock_bias_config_regs_i (
    .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rd_valid(rd_valid),
    .addr_err(addr_err), .ctrl(ctrl));
  // clock at 20 MHz
  initial begin
    forever #25 mclk = ~mclk;
  end
  // ==========================================================
  // compare, bus cycles and reset
  task chk(input string n, input logic [19:0] s, input logic [19:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [8:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    @(posedge mclk);
  endtask
  // read strobe for one cycle; answer checked 1 ns after the edge that samples it
  task automatic rd(input logic [8:0] a, input logic [15:0] e,
    input logic err);
    addr <= a;
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    @(posedge mclk);
    fork
      begin
        #1;
        chk("rdata", rdata, e);
        chk("addr_err", addr_err, err);
        chk("rd_valid", rd_valid, 1'b1);
      end
    join_none
  endtask
  task idle();
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge mclk);
  endtask
  task do_reset();
    reset_n <= 1'b0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask
  task chk_defaults();
    for (int i = 0; i < 11; i++) rd(amap[i], rstv[i], 1'b0);
    idle();
    chk("clk bits", ctrl[38:35], 4'h2);
    chk("pwr bits", ctrl[34:31], 4'h0);
    chk("levels", {ctrl.double_slope_level, ctrl.triple_slope_level},
      8'hA5);
    chk("bias", {ctrl.afe_pwr_up, ctrl.bandgap_pwr_up, ctrl.ext_resistor},
      3'h1);
    chk("currents", ctrl[19:0], 20'h88888);
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    do_reset();
    chk_defaults();
    // inverted words, each read back at once
    for (int i = 0; i < 11; i++) begin
      wr(amap[i], ~rstv[i]);
      rd(amap[i], ~rstv[i], 1'b0);
    end
    idle();
    chk("clk bits", ctrl[38:35], 4'hD);
    chk("pwr bits", ctrl[34:31], 4'hF);
    chk("levels", ctrl[30:23], 8'h5A);
    chk("bias", ctrl[22:20], 3'h6);
    chk("currents", ctrl[19:0], 20'h77777);
    chk("cp", ctrl.charge_pump_current, 4'h7);
    // both enables set, PLL select and 8-bit mode clear on the clock word
    wr(cfg_regs_pkg::ADDR_CLKGEN, 16'h0003);
    idle();
    chk("clk bits", ctrl[38:35], 4'hC);
    // read-modify-write sets the mode bit and keeps the rest
    rd(cfg_regs_pkg::ADDR_CLKGEN, 16'h0003, 1'b0);
    idle();
    wr(cfg_regs_pkg::ADDR_CLKGEN, 16'h0003 | 16'h0008);
    idle();
    chk("clk bits", ctrl[38:35], 4'hD);
    // unmapped places drop writes and read zero
    wr(9'h021, 16'h0000);
    rd(9'h021, 16'h0000, 1'b1);
    rd(9'h022, 16'hFFFF, 1'b0);
    rd(9'h045, 16'h0000, 1'b1);
    rd(9'h1FF, 16'h0000, 1'b1);
    idle();
    // reset in mid-run restores every default
    do_reset();
    chk_defaults();
    tally_and_finish();
  end
  // watchdog far beyond the hundred or so cycles used
  initial begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
bind sensor_clock_bias_config_regs sensor_clock_bias_config_regs_assertions
  sensor_clock_bias_config_regs_assertions_i (.mclk(mclk),
  .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .rd_valid(rd_valid),
  .addr_err(addr_err), .ctrl(ctrl));
